/* File: src/audio_in_pkg.sv */
// Shared constants and types for the serial audio input link
package audio_in_pkg;

  // Framing selected by the two static format pins, in pin-code order
  typedef enum logic [1:0] {
    FMT_RIGHT_JUST,
    FMT_I2S,
    FMT_LEFT_JUST,
    FMT_DSP
  } fmt_e;

  localparam int unsigned WORD_W      = 18;
  localparam int unsigned WORD_W_NARROW = 16;
  localparam int unsigned FRAME_BITS  = 64;
  localparam int unsigned PACKED_BITS = 32;

  // Bit clock made by the source end
  localparam int unsigned SYS_PERIOD_NS  = 40;
  localparam int unsigned BCLK_PERIOD_NS = 320;
  localparam int unsigned BCLK_HALF_CYC  = BCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [2:0]  BCLK_HALF_LAST = 3'(BCLK_HALF_CYC - 1);

  // Rate tracker: period estimate in system cycles, 16 integer and 8 fraction bits
  localparam int unsigned PER_INT_W  = 16;
  localparam int unsigned PER_FRAC_W = 8;
  localparam int unsigned PER_W      = PER_INT_W + PER_FRAC_W;
  localparam int unsigned FAST_SHIFT = 2;
  localparam int unsigned SLOW_SHIFT = 8;
  localparam logic signed [PER_W:0] LOCK_TOL   = 25'sh0000200;
  localparam logic signed [PER_W:0] UNLOCK_TOL = 25'sh0001000;
  localparam logic [7:0]  LOCK_SAMPLES = 8'h40;
  localparam logic [PER_INT_W-1:0] PER_MAX = 16'hFFFF;

endpackage

/* File: src/audio_link_if.sv */
// Serial audio link between a source and the input port
`timescale 1ns/100ps
interface audio_link_if;
  logic bclk;
  logic frame_clk;
  logic serial_audio_in;

  modport src (
    output bclk,
    output frame_clk,
    output serial_audio_in
  );

  modport dev (
    input bclk,
    input frame_clk,
    input serial_audio_in
  );
endinterface

/* File: src/audio_in_port.sv */
// Stereo serial audio input port with frame-clock rate tracker and de-emphasis switches
//
// Functional notes
// - Source keeps frame clock running, two toggles/frame, four in DSP mode.
// - Sample rate comes from frame clock frequency.
// - Only bit clock edges matter; bursts tolerated.
// - Bit clock only shifts data in.
// - Bit clock may be unrelated to frame clock.
// - Words are two's complement, MSB first.
// - Left word precedes right word each frame.
// - Word width 16 or 18 by pin.
// - Two format pins choose among four framings.
// - Right-justified: LSB ends at frame transition.
// - I2S: MSB one bit after transition, low=left.
// - Left-justified: MSB at transition, high=left.
// - DSP mode: frame pulse before each MSB.
// - DSP mode samples on bit clock falling edges.
// - DSP source alternates left then right words.
// - Packed 32-bit frames in 16-bit RJ/LJ.
// - Fast capture then slow narrow-band tracking.
// - De-emphasis pin drives both switch outputs.
`timescale 1ns/100ps
module audio_in_port (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  audio_link_if.dev                  LINK,
  input  wire logic                  PORT_FORMAT_SEL0,
  input  wire logic                  PORT_FORMAT_SEL1,
  input  wire logic                  WIDTH_18,
  input  wire logic                  DEEMPH_ENABLE_PIN,
  output logic                       LEFT_DEEMPH_SWITCH,
  output logic                       RIGHT_DEEMPH_SWITCH,
  output logic [17:0]                LEFT_WORD,
  output logic [17:0]                RIGHT_WORD,
  output logic                       FRAME_VALID,
  output logic [15:0]                RATE_PERIOD,
  output logic                       RATE_LOCKED
);

  typedef struct packed {
    logic [1:0]  bclk_sync;
    logic [1:0]  frame_sync;
    logic [1:0]  data_sync;
    logic [1:0]  sel0_sync;
    logic [1:0]  sel1_sync;
    logic [1:0]  w18_sync;
    logic [1:0]  deemph_sync;
    logic        bclk_prev;
    logic        frame_seen;
    logic        frame_prev_sys;
    logic [17:0] shift;
    logic [4:0]  cnt;
    logic        active;
    logic        chan_left;
    logic        dsp_armed;
    logic        dsp_next_left;
    logic [17:0] left_word;
    logic [17:0] right_word;
    logic        frame_valid;
    logic [15:0] meas;
    logic        meas_started;
    logic [23:0] per_est;
    logic        slow_mode;
    logic [7:0]  good_cnt;
    logic        deemph_l;
    logic        deemph_r;
  } state_s;

  state_s st_reg;
  state_s st_next;

  audio_in_pkg::fmt_e fmt;
  logic               w18;
  logic               bclk_s;
  logic               frame_s;
  logic               data_s;
  logic               samp_edge;
  logic               boundary;
  logic [4:0]         wlen;
  logic [17:0]        shifted;
  logic [17:0]        rj_word;
  logic [16:0]        period_now;
  logic signed [24:0] per_err;
  logic signed [24:0] per_abs;
  logic signed [24:0] per_step;
  logic               deliver;
  logic [17:0]        deliver_word;

  assign fmt     = audio_in_pkg::fmt_e'({st_reg.sel1_sync[1], st_reg.sel0_sync[1]});
  assign w18     = st_reg.w18_sync[1];
  assign bclk_s  = st_reg.bclk_sync[1];
  assign frame_s = st_reg.frame_sync[1];
  assign data_s  = st_reg.data_sync[1];
  assign wlen    = w18 ? 5'(audio_in_pkg::WORD_W) : 5'(audio_in_pkg::WORD_W_NARROW);

  always_comb begin
    st_next = st_reg;
    deliver = 1'b0;
    deliver_word = '0;
    // All external pins pass two flops before use
    st_next.bclk_sync   = {st_reg.bclk_sync[0], LINK.bclk};
    st_next.frame_sync  = {st_reg.frame_sync[0], LINK.frame_clk};
    st_next.data_sync   = {st_reg.data_sync[0], LINK.serial_audio_in};
    st_next.sel0_sync   = {st_reg.sel0_sync[0], PORT_FORMAT_SEL0};
    st_next.sel1_sync   = {st_reg.sel1_sync[0], PORT_FORMAT_SEL1};
    st_next.w18_sync    = {st_reg.w18_sync[0], WIDTH_18};
    st_next.deemph_sync = {st_reg.deemph_sync[0], DEEMPH_ENABLE_PIN};
    st_next.bclk_prev   = bclk_s;
    st_next.frame_valid = 1'b0;

    // A stopped bit clock simply produces no edges, so gated bursts need no special case
    if (fmt == audio_in_pkg::FMT_DSP) begin
      samp_edge = st_reg.bclk_prev & ~bclk_s;
    end else begin
      samp_edge = ~st_reg.bclk_prev & bclk_s;
    end
    boundary = frame_s != st_reg.frame_seen;
    shifted  = {st_reg.shift[16:0], data_s};
    rj_word  = w18 ? st_reg.shift : {st_reg.shift[15:0], 2'b00};

    // Frame level is judged only at sampling edges, so its phase to the bit clock is free
    if (samp_edge) begin
      st_next.frame_seen = frame_s;
      unique case (fmt)
        audio_in_pkg::FMT_RIGHT_JUST: begin
          st_next.shift = shifted;
          // Word of the half just ended is its last wlen bits
          if (boundary) begin
            deliver      = 1'b1;
            deliver_word = rj_word;
            st_next.chan_left = st_reg.frame_seen;
          end
        end
        audio_in_pkg::FMT_I2S, audio_in_pkg::FMT_LEFT_JUST: begin
          if (boundary) begin
            if (fmt == audio_in_pkg::FMT_I2S) begin
              st_next.cnt       = 5'h00;
              st_next.chan_left = ~frame_s;
            end else begin
              st_next.cnt       = 5'h01;
              st_next.shift     = shifted;
              st_next.chan_left = frame_s;
            end
            st_next.active = 1'b1;
          end else if (st_reg.active && st_reg.cnt < wlen) begin
            st_next.shift = shifted;
            st_next.cnt   = 5'(st_reg.cnt + 5'h01);
          end
        end
        audio_in_pkg::FMT_DSP: begin
          if (frame_s) begin
            st_next.dsp_armed = 1'b1;
            st_next.active    = 1'b0;
          end else if (st_reg.dsp_armed) begin
            // Source is trusted to start with left and keep alternating
            st_next.dsp_armed     = 1'b0;
            st_next.active        = 1'b1;
            st_next.cnt           = 5'h01;
            st_next.shift         = shifted;
            st_next.chan_left     = st_reg.dsp_next_left;
            st_next.dsp_next_left = ~st_reg.dsp_next_left;
          end else if (st_reg.active && st_reg.cnt < wlen) begin
            st_next.shift = shifted;
            st_next.cnt   = 5'(st_reg.cnt + 5'h01);
          end
        end
      endcase
      if (fmt != audio_in_pkg::FMT_RIGHT_JUST && st_next.active && st_next.cnt == wlen) begin
        deliver        = 1'b1;
        deliver_word   = w18 ? st_next.shift : {st_next.shift[15:0], 2'b00};
        st_next.active = 1'b0;
      end
    end
    if (deliver) begin
      if (st_next.chan_left) begin
        st_next.left_word = deliver_word;
      end else begin
        st_next.right_word  = deliver_word;
        st_next.frame_valid = 1'b1;
      end
    end

    // Rate tracker runs on frame clock rising edges in the system domain only
    period_now = {1'b0, st_reg.meas} + 17'h00001;
    per_err    = 25'sd0;
    per_abs    = 25'sd0;
    per_step   = 25'sd0;
    if (st_reg.meas != audio_in_pkg::PER_MAX) begin
      st_next.meas = 16'(st_reg.meas + 16'h0001);
    end
    st_next.frame_prev_sys = frame_s;
    if (frame_s && !st_reg.frame_prev_sys) begin
      st_next.meas         = 16'h0000;
      st_next.meas_started = 1'b1;
      // DSP pulses twice per stereo sample, so the measured span is half a period
      if (fmt == audio_in_pkg::FMT_DSP) begin
        period_now = {period_now[15:0], 1'b0};
      end
      if (st_reg.meas_started) begin
        per_err = $signed({1'b0, period_now[15:0], 8'h00}) - $signed({1'b0, st_reg.per_est});
        per_abs = per_err < 0 ? -per_err : per_err;
        // Wide capture first; narrow loop once the estimate sits still
        per_step = st_reg.slow_mode ? (per_err >>> audio_in_pkg::SLOW_SHIFT)
                                    : (per_err >>> audio_in_pkg::FAST_SHIFT);
        st_next.per_est = 24'($signed({1'b0, st_reg.per_est}) + per_step);
        if (per_abs < audio_in_pkg::LOCK_TOL) begin
          if (st_reg.good_cnt == audio_in_pkg::LOCK_SAMPLES) begin
            st_next.slow_mode = 1'b1;
          end else begin
            st_next.good_cnt = 8'(st_reg.good_cnt + 8'h01);
          end
        end else if (per_abs > audio_in_pkg::UNLOCK_TOL) begin
          st_next.good_cnt  = 8'h00;
          st_next.slow_mode = 1'b0;
        end
      end
    end

    st_next.deemph_l = st_reg.deemph_sync[1];
    st_next.deemph_r = st_reg.deemph_sync[1];
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.dsp_next_left <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign LEFT_DEEMPH_SWITCH  = st_reg.deemph_l;
  assign RIGHT_DEEMPH_SWITCH = st_reg.deemph_r;
  assign LEFT_WORD           = st_reg.left_word;
  assign RIGHT_WORD          = st_reg.right_word;
  assign FRAME_VALID         = st_reg.frame_valid;
  assign RATE_PERIOD         = st_reg.per_est[23:8];
  assign RATE_LOCKED         = st_reg.slow_mode;

endmodule

/* File: src/audio_src_port.sv */
// Serial audio source: makes bit and frame clocks and shifts stereo words out
`timescale 1ns/100ps
module audio_src_port (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  audio_link_if.src        LINK,
  input  wire logic        PORT_FORMAT_SEL0,
  input  wire logic        PORT_FORMAT_SEL1,
  input  wire logic        WIDTH_18,
  input  wire logic        PACKED,
  input  wire logic [17:0] SAMPLE_LEFT,
  input  wire logic [17:0] SAMPLE_RIGHT,
  output logic             SAMPLE_TAKE
);

  typedef struct packed {
    logic [2:0]  div;
    logic        bclk;
    logic [5:0]  pos;
    logic        frame;
    logic        data;
    logic [17:0] lw;
    logic [17:0] rw;
    logic        take;
    logic        run;
  } state_s;

  state_s st_reg;
  state_s st_next;

  audio_in_pkg::fmt_e fmt;
  logic               packed_on;
  logic [5:0]         last_pos;
  logic [5:0]         half;
  logic               drive_lvl;

  assign fmt       = audio_in_pkg::fmt_e'({PORT_FORMAT_SEL1, PORT_FORMAT_SEL0});
  // Packed framing exists only for 16-bit right- or left-justified
  assign packed_on = PACKED && !WIDTH_18 &&
                     (fmt == audio_in_pkg::FMT_RIGHT_JUST || fmt == audio_in_pkg::FMT_LEFT_JUST);
  assign last_pos  = packed_on ? 6'(audio_in_pkg::PACKED_BITS - 1)
                               : 6'(audio_in_pkg::FRAME_BITS - 1);
  assign half      = packed_on ? 6'(audio_in_pkg::PACKED_BITS / 2)
                               : 6'(audio_in_pkg::FRAME_BITS / 2);
  // Drive on the edge opposite to the one the port samples on
  assign drive_lvl = fmt == audio_in_pkg::FMT_DSP;

  // Returns {frame level, data bit} for bit position p of a frame
  function automatic logic [1:0] slot_bits(input logic [5:0] p, input logic [17:0] l,
                                           input logic [17:0] r);
    logic        left;
    logic [5:0]  s;
    logic [17:0] w;
    int          i;
    int          wl;
    logic        fr;
    left = p < half;
    s    = left ? p : 6'(p - half);
    w    = left ? l : r;
    wl   = WIDTH_18 ? audio_in_pkg::WORD_W : audio_in_pkg::WORD_W_NARROW;
    unique case (fmt)
      audio_in_pkg::FMT_RIGHT_JUST: begin
        i  = int'(s) - (int'(half) - wl);
        fr = left;
      end
      audio_in_pkg::FMT_I2S: begin
        i  = int'(s) - 1;
        fr = ~left;
      end
      audio_in_pkg::FMT_LEFT_JUST: begin
        i  = int'(s);
        fr = left;
      end
      audio_in_pkg::FMT_DSP: begin
        i  = int'(s);
        fr = (p == last_pos) || (p == 6'(half - 6'h01));
      end
    endcase
    // MSB first; 16-bit words occupy the top of the 18-bit input
    slot_bits = {fr, (i >= 0 && i < wl) ? w[17 - i] : 1'b0};
  endfunction

  always_comb begin
    logic [5:0] np;
    logic [1:0] fd;
    np = '0;
    fd = '0;
    st_next      = st_reg;
    st_next.take = 1'b0;
    if (st_reg.div == audio_in_pkg::BCLK_HALF_LAST) begin
      st_next.div  = 3'h0;
      st_next.bclk = ~st_reg.bclk;
      // Frame clock runs free from reset with fixed bit count per frame
      if (~st_reg.bclk == drive_lvl) begin
        np = (st_reg.pos >= last_pos) ? 6'h00 : 6'(st_reg.pos + 6'h01);
        // A DSP stream opens with a pulse, so the first word the port sees is left
        if (!st_reg.run && fmt == audio_in_pkg::FMT_DSP) begin
          np = last_pos;
        end
        st_next.run = 1'b1;
        st_next.pos = np;
        if (np == 6'h00) begin
          st_next.lw   = SAMPLE_LEFT;
          st_next.rw   = SAMPLE_RIGHT;
          st_next.take = 1'b1;
        end
        fd = slot_bits(np, st_next.lw, st_next.rw);
        st_next.frame = fd[1];
        st_next.data  = fd[0];
      end
    end else begin
      st_next.div = 3'(st_reg.div + 3'h1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_reg     <= '0;
      st_reg.pos <= 6'h3F;
    end else begin
      st_reg <= st_next;
    end
  end

  assign LINK.bclk            = st_reg.bclk;
  assign LINK.frame_clk       = st_reg.frame;
  assign LINK.serial_audio_in = st_reg.data;
  assign SAMPLE_TAKE          = st_reg.take;

endmodule

/* File: tb/audio_link_properties.sv */
// Wire-level properties of the serial audio link between source and input port
`timescale 1ns/100ps
module audio_link_properties (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic bclk,
  input wire logic frame_clk,
  input wire logic serial_audio_in
);
  logic       bclk_reg;
  logic       frame_reg;
  logic       seen_reg;
  logic [6:0] cnt_reg;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Bit clock rises since the last frame rise; a rise on that same edge opens the new count
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bclk_reg  <= 1'b0;
      frame_reg <= 1'b0;
      seen_reg  <= 1'b0;
      cnt_reg   <= 7'h00;
    end else begin
      bclk_reg  <= bclk;
      frame_reg <= frame_clk;
      if (frame_clk && !frame_reg) begin
        seen_reg <= 1'b1;
        cnt_reg  <= 7'(bclk && !bclk_reg);
      end else begin
        cnt_reg <= cnt_reg + 7'(bclk && !bclk_reg);
      end
    end
  end

  a_bclk_half_steady: assert property ($changed(bclk) |=> $stable(bclk) [*3])
    else $error("bit clock changed before its half period ended");
  a_bclk_keeps_running: assert property ($changed(bclk) |-> ##4 $changed(bclk))
    else $error("bit clock half period not four cycles");
  a_frame_on_bclk: assert property ($changed(frame_clk) |-> $changed(bclk))
    else $error("frame clock moved away from a bit clock edge");
  a_data_on_bclk: assert property ($changed(serial_audio_in) |-> $changed(bclk))
    else $error("serial data moved away from a bit clock edge");
  a_data_holds_half: assert property (
    $changed(serial_audio_in) |=> $stable(serial_audio_in) [*3])
    else $error("serial data not held for a half bit period");
  a_frame_holds_bit: assert property ($changed(frame_clk) |=> $stable(frame_clk) [*7])
    else $error("frame clock level shorter than one bit period");
  a_frame_keeps_running: assert property (
    $changed(frame_clk) |-> ##[1:256] $changed(frame_clk))
    else $error("frame clock stopped");
  a_frame_bit_count: assert property (
    $rose(frame_clk) && seen_reg |-> (cnt_reg == 7'h40 || cnt_reg == 7'h20))
    else $error("bit clocks per frame neither 64 nor 32");

  c_full_frame: cover property ($rose(frame_clk) && seen_reg && cnt_reg == 7'h40);
  c_short_frame: cover property ($rose(frame_clk) && seen_reg && cnt_reg == 7'h20);
  c_data_moves: cover property ($changed(serial_audio_in));
endmodule

/* File: tb/stereo_serial_audio_input_port_test.sv */
// Bench joining the audio source and the input port back to back over the link
`timescale 1ns/100ps
module stereo_serial_audio_input_port_test;
  logic        clk_sys;
  logic        rstn;
  logic [1:0]  fmt;
  logic        width_18;
  logic        packed_mode;
  logic        deemph;
  logic [17:0] smp_l;
  logic [17:0] smp_r;
  logic        left_sw;
  logic        right_sw;
  logic [17:0] left_word;
  logic [17:0] right_word;
  logic        frame_valid;
  logic [15:0] rate_period;
  logic        rate_locked;
  logic        sample_take;
  int          n_mismatch;
  int          n_checks;

  audio_link_if link ();

  audio_in_port i_audio_in_port (
    .CLK_SYS            (clk_sys),
    .RSTN               (rstn),
    .LINK               (link),
    .PORT_FORMAT_SEL0   (fmt[0]),
    .PORT_FORMAT_SEL1   (fmt[1]),
    .WIDTH_18           (width_18),
    .DEEMPH_ENABLE_PIN  (deemph),
    .LEFT_DEEMPH_SWITCH (left_sw),
    .RIGHT_DEEMPH_SWITCH(right_sw),
    .LEFT_WORD          (left_word),
    .RIGHT_WORD         (right_word),
    .FRAME_VALID        (frame_valid),
    .RATE_PERIOD        (rate_period),
    .RATE_LOCKED        (rate_locked)
  );

  audio_src_port i_audio_src_port (
    .CLK_SYS         (clk_sys),
    .RSTN            (rstn),
    .LINK            (link),
    .PORT_FORMAT_SEL0(fmt[0]),
    .PORT_FORMAT_SEL1(fmt[1]),
    .WIDTH_18        (width_18),
    .PACKED          (packed_mode),
    .SAMPLE_LEFT     (smp_l),
    .SAMPLE_RIGHT    (smp_r),
    .SAMPLE_TAKE     (sample_take)
  );

  audio_link_properties i_audio_link_properties (
    .CLK_SYS        (clk_sys),
    .RSTN           (rstn),
    .bclk           (link.bclk),
    .frame_clk      (link.frame_clk),
    .serial_audio_in(link.serial_audio_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [17:0] exp, logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Static pins may only change under reset, so every setting starts a fresh link
  task automatic setup(logic [1:0] f, logic w, logic p, logic [17:0] l, logic [17:0] r);
    @(posedge clk_sys);
    rstn        <= 1'b0;
    fmt         <= f;
    width_18    <= w;
    packed_mode <= p;
    smp_l       <= l;
    smp_r       <= r;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask

  // The first frame after release may be partial, so judge the third
  task automatic words(logic [17:0] l, logic [17:0] r);
    int n = 3;
    int k = 0;
    while (n > 0 && k < 2000) begin
      @(negedge clk_sys);
      k++;
      if (frame_valid === 1'b1) begin
        n--;
        k = 0;
      end
    end
    check("FRAME_VALID", 18'h00000, 18'(n));
    check("LEFT_WORD", width_18 ? l : {l[17:2], 2'h0}, left_word);
    check("RIGHT_WORD", width_18 ? r : {r[17:2], 2'h0}, right_word);
  endtask

  // Take pulses come once a frame; the tracker must then settle on that frame period
  task automatic rate_lock(logic [17:0] half_per);
    int k = 0;
    @(negedge clk_sys iff sample_take === 1'b1);
    do begin
      @(negedge clk_sys);
      k++;
    end while (sample_take !== 1'b1 && k < 2000);
    check("SAMPLE_TAKE", half_per << 1, 18'(k));
    k = 0;
    while (rate_locked !== 1'b1 && k < 40000) begin
      @(negedge clk_sys);
      k++;
    end
    check("RATE_LOCKED", 18'h00001, 18'(rate_locked));
    check("RATE_PERIOD", half_per, 18'((rate_period + 16'h0001) >> 1));
  endtask

  task automatic t_right_just;
    setup(audio_in_pkg::FMT_RIGHT_JUST, 1'b1, 1'b0, 18'h20000, 18'h1FFFF);
    words(18'h20000, 18'h1FFFF);
    setup(audio_in_pkg::FMT_RIGHT_JUST, 1'b0, 1'b1, 18'h3FFFF, 18'h0A5A7);
    words(18'h3FFFF, 18'h0A5A7);
  endtask

  task automatic t_i2s;
    setup(audio_in_pkg::FMT_I2S, 1'b1, 1'b0, 18'h2A5C3, 18'h15A3C);
    words(18'h2A5C3, 18'h15A3C);
    setup(audio_in_pkg::FMT_I2S, 1'b0, 1'b0, 18'h31E07, 18'h0C1F3);
    words(18'h31E07, 18'h0C1F3);
  endtask

  task automatic t_left_just;
    setup(audio_in_pkg::FMT_LEFT_JUST, 1'b1, 1'b0, 18'h00001, 18'h3FFFE);
    words(18'h00001, 18'h3FFFE);
  endtask

  task automatic t_dsp;
    setup(audio_in_pkg::FMT_DSP, 1'b1, 1'b0, 18'h2C3A5, 18'h13C5A);
    words(18'h2C3A5, 18'h13C5A);
    setup(audio_in_pkg::FMT_DSP, 1'b0, 1'b0, 18'h0F0F3, 18'h30F0C);
    words(18'h0F0F3, 18'h30F0C);
    // Two pulses a frame, yet the estimate must be the full 512-cycle stereo period
    rate_lock(18'h00100);
  endtask

  // Packed frames last 256 cycles, so the estimate settles to 255 or 256
  task automatic t_rate_track;
    setup(audio_in_pkg::FMT_LEFT_JUST, 1'b0, 1'b1, 18'h24683, 18'h1B97F);
    words(18'h24683, 18'h1B97F);
    rate_lock(18'h00080);
  endtask

  task automatic t_deemph;
    logic t;
    repeat (2) begin
      t = !deemph;
      @(posedge clk_sys);
      deemph <= t;
      repeat (2) @(posedge clk_sys);
      #1;
      check("LEFT_DEEMPH_SWITCH", 18'(!t), 18'(left_sw));
      @(posedge clk_sys);
      #1;
      check("LEFT_DEEMPH_SWITCH", 18'(t), 18'(left_sw));
      check("RIGHT_DEEMPH_SWITCH", 18'(t), 18'(right_sw));
    end
  endtask

  initial begin
    rstn        = 1'b0;
    fmt         = 2'h0;
    width_18    = 1'b1;
    packed_mode = 1'b0;
    deemph      = 1'b0;
    smp_l       = 18'h00000;
    smp_r       = 18'h00000;
    n_mismatch  = 0;
    n_checks    = 0;
    t_right_just();
    t_i2s();
    t_left_just();
    t_dsp();
    t_rate_track();
    t_deemph();
    final_report();
  end

  // All scenarios need about 50000 cycles, two lock waits being the bulk
  initial begin
    #(90000 * 40);
    n_mismatch++;
    final_report();
  end
endmodule
